// ===== rtl/mppa_pkg.sv
package mppa_pkg;
  // ---------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CV29 = 8'h08;
  localparam logic [7:0] ADDR_CV49 = 8'h0c;
  localparam logic [7:0] ADDR_CV113 = 8'h10;
  localparam logic [7:0] ADDR_ADDRESS = 8'h14;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CV49_NOAUTO_BIT = 4;
  localparam int CV29_STEPS_BIT = 1;
  localparam int CTRL_AUX_SEL_BIT = 0;
  localparam logic [7:0] RST_ADDRESS = 8'h03;
  localparam logic [7:0] RST_CV29 = 8'h00;
  localparam logic [7:0] RST_CV49 = 8'h00;
  localparam logic [7:0] RST_CV113 = 8'h00;
  localparam logic [7:0] LEGACY_ADDR_MIN = 8'h01;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int LOCK_TIMEOUT_MS = 4000;
  localparam longint LOCK_TIMEOUT_CYC = longint'(LOCK_TIMEOUT_MS) * 1000 * CLOCK_MHZ;
  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MPPA_FMT_FBDCC, MPPA_FMT_AUTOREG, MPPA_FMT_DCC, MPPA_FMT_TRINARY, MPPA_FMT_PARALLEL
  } mppa_fmt_t;
  typedef enum logic [1:0] {
    MPPA_STEPS_14, MPPA_STEPS_28, MPPA_STEPS_128
  } mppa_steps_t;
  typedef enum logic [1:0] {
    MPPA_DET_WAIT, MPPA_DET_DONE, MPPA_DET_OFF
  } mppa_det_t;
endpackage

// ===== rtl/mppa_multi_protocol_packet_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module mppa_multi_protocol_packet_arbiter
  import mppa_pkg::*;
#(
  parameter longint LOCK_CYCLES = LOCK_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic haddrSel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pktValid,
  input wire logic [2:0] pktFormat,
  input wire logic pktCrcOk,
  input wire logic [7:0] pktAddress,
  input wire logic pktSteps28,
  input wire logic pktLightsBit,
  input wire logic pktNewFormat,
  input wire logic [4:0] pktKeys,
  input wire logic pktProgram,
  input wire logic analogPin,
  output logic acceptStrobe,
  output logic [2:0] acceptFormat,
  output logic [1:0] speedSteps,
  output logic lightsKey,
  output logic soundOn,
  output logic hornPulse,
  output logic parallelRxEnable,
  output logic autoregLock,
  output logic programStrobe,
  output logic aux_output_seven,
  output logic aux_output_nine
);
  // ---------------------------------------------------------------
  // checks and state
  // ---------------------------------------------------------------
  if (LOCK_CYCLES < 2 || LOCK_CYCLES > 64'hffff_ffff) begin
    $error("LOCK_CYCLES out of range");
  end

  typedef struct packed {
    logic anaS1;
    logic anaS2;
    logic [31:0] lockCnt;
    logic lock;
    logic parEn;
    mppa_det_t det;
    mppa_steps_t steps;
    logic [7:0] cv29;
    logic [7:0] cv49;
    logic [7:0] cv113;
    logic [7:0] addr;
    logic auxSel;
    logic wPend;
    logic [7:0] wAddr;
    logic [31:0] rdata;
    logic acc;
    logic [2:0] accFmt;
    logic lights;
    logic sound;
    logic horn;
    logic prog;
    logic bufOn;
    logic [15:0] bufCnt;
  } mppa_state_t;

  mppa_state_t s_q, s_d;
  logic own, fmtOk, locked;

  function automatic logic is_fmt(input logic [2:0] f, input mppa_fmt_t e);
    return f == 3'(e);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.anaS1 = analogPin;
    s_d.anaS2 = s_q.anaS1;
    s_d.acc = 1'b0;
    s_d.horn = 1'b0;
    s_d.prog = 1'b0;
    // trinary also needs the address in 1..255, all formats compare the programmed address
    if (is_fmt(pktFormat, MPPA_FMT_TRINARY)) begin
      own = pktAddress >= LEGACY_ADDR_MIN && pktAddress == s_q.addr;
    end else begin
      own = pktAddress == s_q.addr;
    end
    locked = s_q.lock && (is_fmt(pktFormat, MPPA_FMT_DCC) || is_fmt(pktFormat, MPPA_FMT_TRINARY)
      || is_fmt(pktFormat, MPPA_FMT_PARALLEL));
    fmtOk = !locked && !(is_fmt(pktFormat, MPPA_FMT_PARALLEL) && !s_q.parEn);
    // lockout time-out; only validated auto-reg packets to our own address restart it
    if (s_q.lock) begin
      if (s_q.lockCnt == 32'(LOCK_CYCLES - 1)) begin
        s_d.lock = 1'b0;
      end else begin
        s_d.lockCnt = s_q.lockCnt + 32'h1;
      end
    end
    if (pktValid && pktCrcOk && own && fmtOk) begin
      s_d.acc = 1'b1;
      s_d.accFmt = pktFormat;
      if (is_fmt(pktFormat, MPPA_FMT_AUTOREG)) begin
        s_d.lock = 1'b1;
        s_d.lockCnt = 32'h0;
      end
      if (!is_fmt(pktFormat, MPPA_FMT_PARALLEL)) begin
        s_d.parEn = 1'b0;
      end
      s_d.lights = pktLightsBit;
      if (is_fmt(pktFormat, MPPA_FMT_PARALLEL)) begin
        // only lights and key one reach through here
        if (pktKeys[1] && !s_q.sound) begin
          s_d.sound = 1'b1;
        end else if (!pktKeys[1]) begin
          s_d.sound = 1'b0;
        end
      end else begin
        // trinary keys need the newer format from the station
        if (!is_fmt(pktFormat, MPPA_FMT_TRINARY) || pktNewFormat) begin
          s_d.sound = pktKeys[1];
          s_d.horn = pktKeys[2];
        end
        s_d.prog = pktProgram;
      end
      // detection locks in at first lit dcc packet after power-up
      if (s_q.det == MPPA_DET_WAIT && pktLightsBit
          && (is_fmt(pktFormat, MPPA_FMT_DCC) || is_fmt(pktFormat, MPPA_FMT_FBDCC))) begin
        s_d.steps = pktSteps28 ? MPPA_STEPS_28 : MPPA_STEPS_14;
        s_d.det = MPPA_DET_DONE;
      end
    end
    // detection off is decided once per power-up
    if (s_q.det == MPPA_DET_WAIT && s_q.cv49[CV49_NOAUTO_BIT]) begin
      s_d.det = MPPA_DET_OFF;
    end
    if (s_q.det == MPPA_DET_OFF) begin
      s_d.steps = s_q.cv29[CV29_STEPS_BIT] ? MPPA_STEPS_128 : MPPA_STEPS_14;
    end
    // energy buffer: digital only, hold time from cv113
    if (s_q.anaS2) begin
      s_d.bufOn = 1'b0;
      s_d.bufCnt = 16'h0;
    end else if (s_q.acc) begin
      s_d.bufOn = 1'b1;
      s_d.bufCnt = {s_q.cv113, 8'h00};
    end else if (s_q.bufCnt != 16'h0) begin
      s_d.bufCnt = s_q.bufCnt - 16'h1;
    end else begin
      s_d.bufOn = 1'b0;
    end
    // ahb-lite slave, zero wait, write lands in the data phase
    s_d.wPend = 1'b0;
    if (s_q.wPend) begin
      unique case (s_q.wAddr)
        ADDR_CTRL: s_d.auxSel = hwdata[CTRL_AUX_SEL_BIT];
        ADDR_CV29: s_d.cv29 = hwdata[7:0];
        ADDR_CV49: s_d.cv49 = hwdata[7:0];
        ADDR_CV113: s_d.cv113 = hwdata[7:0];
        ADDR_ADDRESS: s_d.addr = hwdata[7:0];
        default: ;
      endcase
    end
    if (haddrSel && hready && htrans[1]) begin
      s_d.wPend = hwrite;
      s_d.wAddr = haddr[7:0];
      unique case (haddr[7:0])
        ADDR_CTRL: s_d.rdata = {31'h0, s_q.auxSel};
        ADDR_STATUS: s_d.rdata = {22'h0, s_q.bufOn, s_q.det, s_q.steps, s_q.parEn, s_q.lock,
          s_q.lights, s_q.sound, 1'b0};
        ADDR_CV29: s_d.rdata = {24'h0, s_q.cv29};
        ADDR_CV49: s_d.rdata = {24'h0, s_q.cv49};
        ADDR_CV113: s_d.rdata = {24'h0, s_q.cv113};
        ADDR_ADDRESS: s_d.rdata = {24'h0, s_q.addr};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers; rst_n models the power interruption
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.parEn <= 1'b1;
      s_q.addr <= RST_ADDRESS;
      s_q.steps <= MPPA_STEPS_14;
      s_q.cv29 <= RST_CV29;
      s_q.cv49 <= RST_CV49;
      s_q.cv113 <= RST_CV113;
      s_q.det <= MPPA_DET_WAIT;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acceptStrobe = s_q.acc;
  assign acceptFormat = s_q.accFmt;
  assign speedSteps = s_q.steps;
  assign lightsKey = s_q.lights;
  assign soundOn = s_q.sound;
  assign hornPulse = s_q.horn;
  assign parallelRxEnable = s_q.parEn;
  assign autoregLock = s_q.lock;
  assign programStrobe = s_q.prog;
  assign aux_output_seven = s_q.bufOn && !s_q.auxSel;
  assign aux_output_nine = s_q.bufOn && s_q.auxSel;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_lock_drops_plain;
    @(posedge clock) disable iff (!rst_n)
      s_q.lock && pktValid && is_fmt(pktFormat, MPPA_FMT_DCC) |=> !acceptStrobe;
  endproperty
  a_lock_drops_plain: assert property (p_lock_drops_plain) else $error("plain dcc accepted in lockout");

  property p_lock_sets;
    @(posedge clock) disable iff (!rst_n)
      pktValid && pktCrcOk && own && is_fmt(pktFormat, MPPA_FMT_AUTOREG) |=> autoregLock;
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lockout not set");

  property p_par_off;
    @(posedge clock) disable iff (!rst_n)
      acceptStrobe && !is_fmt(acceptFormat, MPPA_FMT_PARALLEL) |-> !parallelRxEnable;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parallel receiver still on");

  property p_par_stays;
    @(posedge clock) disable iff (!rst_n)
      !parallelRxEnable |=> !parallelRxEnable;
  endproperty
  a_par_stays: assert property (p_par_stays) else $error("parallel receiver came back");

  property p_fb_top;
    @(posedge clock) disable iff (!rst_n)
      pktValid && pktCrcOk && own && is_fmt(pktFormat, MPPA_FMT_FBDCC) |=> acceptStrobe;
  endproperty
  a_fb_top: assert property (p_fb_top) else $error("feedback dcc refused");

  property p_par_low;
    @(posedge clock) disable iff (!rst_n)
      pktValid && is_fmt(pktFormat, MPPA_FMT_PARALLEL) && !parallelRxEnable |=> !acceptStrobe;
  endproperty
  a_par_low: assert property (p_par_low) else $error("parallel packet accepted while off");

  property p_bad_ignored;
    @(posedge clock) disable iff (!rst_n)
      pktValid && !pktCrcOk |=> !acceptStrobe && !$rose(autoregLock);
  endproperty
  a_bad_ignored: assert property (p_bad_ignored) else $error("bad packet had effect");

  property p_buf_analog;
    @(posedge clock) disable iff (!rst_n)
      s_q.anaS2 |=> !aux_output_seven && !aux_output_nine;
  endproperty
  a_buf_analog: assert property (p_buf_analog) else $error("buffer on in analog");

  property p_bad_no_restart;
    @(posedge clock) disable iff (!rst_n)
      pktValid && (!pktCrcOk || !own) && s_q.lock |=> s_q.lockCnt != 32'h0;
  endproperty
  a_bad_no_restart: assert property (p_bad_no_restart) else $error("time-out restarted");

  property p_lock_times_out;
    @(posedge clock) disable iff (!rst_n)
      s_q.lock && s_q.lockCnt == 32'(LOCK_CYCLES - 1)
        && !(pktValid && pktCrcOk && own && is_fmt(pktFormat, MPPA_FMT_AUTOREG)) |=> !autoregLock;
  endproperty
  a_lock_times_out: assert property (p_lock_times_out) else $error("lockout did not time out");

  property p_trin_lock;
    @(posedge clock) disable iff (!rst_n)
      s_q.lock && pktValid && is_fmt(pktFormat, MPPA_FMT_TRINARY) |=> !acceptStrobe;
  endproperty
  a_trin_lock: assert property (p_trin_lock) else $error("trinary accepted in lockout");

  property p_prog_par;
    @(posedge clock) disable iff (!rst_n)
      acceptStrobe && is_fmt(acceptFormat, MPPA_FMT_PARALLEL) |-> !programStrobe;
  endproperty
  a_prog_par: assert property (p_prog_par) else $error("programming through parallel");

  property p_horn_key;
    @(posedge clock) disable iff (!rst_n)
      pktValid && pktCrcOk && own && fmtOk && is_fmt(pktFormat, MPPA_FMT_DCC) && pktKeys[2] |=> hornPulse;
  endproperty
  a_horn_key: assert property (p_horn_key) else $error("horn key ignored");

  property p_sound_key;
    @(posedge clock) disable iff (!rst_n)
      pktValid && pktCrcOk && own && fmtOk && is_fmt(pktFormat, MPPA_FMT_DCC) |=> soundOn == $past(pktKeys[1]);
  endproperty
  a_sound_key: assert property (p_sound_key) else $error("sound does not follow key one");

  property p_steps_off;
    @(posedge clock) disable iff (!rst_n)
      s_q.det == MPPA_DET_OFF && s_q.cv29[CV29_STEPS_BIT] |=> speedSteps == 2'(MPPA_STEPS_128);
  endproperty
  a_steps_off: assert property (p_steps_off) else $error("steps not taken from cv29");

  property p_steps_hold;
    @(posedge clock) disable iff (!rst_n)
      s_q.det == MPPA_DET_DONE |=> $stable(speedSteps);
  endproperty
  a_steps_hold: assert property (p_steps_hold) else $error("steps changed without power cycle");

  property p_buf_digital;
    @(posedge clock) disable iff (!rst_n)
      acceptStrobe && !s_q.anaS2 |=> aux_output_seven || aux_output_nine;
  endproperty
  a_buf_digital: assert property (p_buf_digital) else $error("buffer not engaged in digital");
endmodule
`default_nettype wire

// ===== verification/mppa_station_model.sv
`timescale 1ns/1ps
`default_nettype none
module mppa_station_model
  import mppa_pkg::*;
(
  input wire logic clock,
  output logic pktValid,
  output logic [2:0] pktFormat,
  output logic pktCrcOk,
  output logic [7:0] pktAddress,
  output logic pktSteps28,
  output logic pktLightsBit,
  output logic pktNewFormat,
  output logic [4:0] pktKeys,
  output logic pktProgram
);
  // ----
  // packet sender
  // ----
  initial begin
    {pktValid, pktFormat, pktCrcOk, pktAddress, pktSteps28, pktLightsBit, pktNewFormat, pktKeys, pktProgram} = '0;
  end
  task automatic send(input logic [2:0] f, input logic [7:0] a, input logic c, input logic s, input logic [4:0] k,
                      input logic p);
    @(posedge clock);
    pktValid <= 1'b1;
    pktFormat <= f;
    pktCrcOk <= c;
    pktAddress <= a;
    pktSteps28 <= s;
    pktKeys <= k;
    pktProgram <= p;
    pktLightsBit <= 1'b1;
    pktNewFormat <= (f == MPPA_FMT_TRINARY);
    @(posedge clock);
    // address, keys and crc are not held once the packet is over
    pktValid <= 1'b0;
    pktAddress <= ~a;
    pktKeys <= ~k;
    pktCrcOk <= ~c;
  endtask
endmodule
`default_nettype wire

// ===== verification/multi_protocol_packet_arbiter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module multi_protocol_packet_arbiter_tb
  import mppa_pkg::*;
;
  logic clock, rst_n, haddrSel, hwrite, hreadyout, hresp, analogPin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, speedSteps;
  logic [2:0] hsize, pktFormat, acceptFormat;
  logic pktValid, pktCrcOk, pktSteps28, pktLightsBit, pktNewFormat, pktProgram;
  logic [7:0] pktAddress, own;
  logic [4:0] pktKeys;
  logic acceptStrobe, lightsKey, soundOn, hornPulse, parallelRxEnable, autoregLock, programStrobe, auxSeven, auxNine;
  int failures = 0;
  int check_count = 0;
  // short lock time keeps the run small
  mppa_multi_protocol_packet_arbiter #(.LOCK_CYCLES(100)) u_mppa_multi_protocol_packet_arbiter (
    .clock(clock), .rst_n(rst_n), .haddrSel(haddrSel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pktValid(pktValid), .pktFormat(pktFormat), .pktCrcOk(pktCrcOk), .pktAddress(pktAddress),
    .pktSteps28(pktSteps28), .pktLightsBit(pktLightsBit), .pktNewFormat(pktNewFormat), .pktKeys(pktKeys),
    .pktProgram(pktProgram), .analogPin(analogPin), .acceptStrobe(acceptStrobe), .acceptFormat(acceptFormat),
    .speedSteps(speedSteps), .lightsKey(lightsKey), .soundOn(soundOn), .hornPulse(hornPulse),
    .parallelRxEnable(parallelRxEnable), .autoregLock(autoregLock), .programStrobe(programStrobe),
    .aux_output_seven(auxSeven), .aux_output_nine(auxNine));
  mppa_station_model u_mppa_station_model (
    .clock(clock), .pktValid(pktValid), .pktFormat(pktFormat), .pktCrcOk(pktCrcOk), .pktAddress(pktAddress),
    .pktSteps28(pktSteps28), .pktLightsBit(pktLightsBit), .pktNewFormat(pktNewFormat), .pktKeys(pktKeys),
    .pktProgram(pktProgram));
  // ----
  // tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic pkt(input logic [2:0] f, input logic [7:0] a, input logic c, input logic s, input logic [4:0] k,
                     input logic p, input logic e);
    u_mppa_station_model.send(f, a, c, s, k, p);
    #1;
    `CHK("accept", e, acceptStrobe)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    {rst_n, haddr, htrans, hwrite, hwdata, analogPin} = '0;
    haddrSel = 1'b1;
    hsize = 3'b010;
    own = RST_ADDRESS;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    settle(1);
    `CHK("steps", MPPA_STEPS_14, speedSteps)
    ahb(0, ADDR_ADDRESS, 0);
    `CHK("address", 32'h3, rd)
    `CHK("hresp", 1'b0, hresp)
    ahb(0, 8'h40, 0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1, ADDR_CV113, 32'hffff_ff01);
    ahb(0, ADDR_CV113, 0);
    `CHK("cv113", 32'h1, rd)
    $display("test registers done");
    pkt(MPPA_FMT_PARALLEL, own, 1, 0, 5'h02, 1, 1);
    `CHK("progPar", 1'b0, programStrobe)
    `CHK("soundPar", 1'b1, soundOn)
    `CHK("lightsPar", 1'b1, lightsKey)
    pkt(MPPA_FMT_PARALLEL, own, 1, 0, 5'h00, 0, 1);
    `CHK("soundPar0", 1'b0, soundOn)
    pkt(MPPA_FMT_DCC, own, 1, 1, 0, 0, 1);
    settle(1);
    `CHK("steps28", MPPA_STEPS_28, speedSteps)
    `CHK("parOff", 1'b0, parallelRxEnable)
    pkt(MPPA_FMT_DCC, own, 1, 0, 0, 0, 1);
    settle(1);
    `CHK("stepsKept", MPPA_STEPS_28, speedSteps)
    pkt(MPPA_FMT_DCC, own, 1, 0, 0, 1, 1);
    `CHK("progDcc", 1'b1, programStrobe)
    pkt(MPPA_FMT_PARALLEL, own, 1, 0, 5'h02, 0, 0);
    $display("test detection done");
    pkt(MPPA_FMT_DCC, own, 1, 1, 5'h02, 0, 1);
    `CHK("soundOn", 1'b1, soundOn)
    pkt(MPPA_FMT_DCC, own, 1, 1, 5'h00, 0, 1);
    `CHK("soundOff", 1'b0, soundOn)
    pkt(MPPA_FMT_DCC, own, 1, 1, 5'h02, 0, 1);
    `CHK("soundBack", 1'b1, soundOn)
    pkt(MPPA_FMT_DCC, own, 1, 1, 5'h04, 0, 1);
    `CHK("horn", 1'b1, hornPulse)
    pkt(MPPA_FMT_DCC, own + 8'h1, 1, 1, 0, 0, 0);
    pkt(MPPA_FMT_DCC, own, 0, 1, 0, 0, 0);
    own = 8'hff;
    ahb(1, ADDR_ADDRESS, {24'h0, own});
    pkt(MPPA_FMT_TRINARY, own, 1, 1, 0, 0, 1);
    pkt(MPPA_FMT_TRINARY, 8'hfe, 1, 0, 0, 0, 0);
    pkt(MPPA_FMT_TRINARY, own, 1, 0, 0, 0, 1);
    $display("test keys done");
    pkt(MPPA_FMT_AUTOREG, own, 1, 1, 0, 0, 1);
    `CHK("lock", 1'b1, autoregLock)
    pkt(MPPA_FMT_DCC, own, 1, 1, 0, 0, 0);
    pkt(MPPA_FMT_TRINARY, own, 1, 1, 0, 0, 0);
    pkt(MPPA_FMT_FBDCC, own, 1, 1, 0, 0, 1);
    `CHK("fmtFb", MPPA_FMT_FBDCC, acceptFormat)
    settle(40);
    pkt(MPPA_FMT_AUTOREG, 8'h01, 1, 1, 0, 0, 0);
    settle(30);
    `CHK("lockHeld", 1'b1, autoregLock)
    settle(60);
    `CHK("lockGone", 1'b0, autoregLock)
    pkt(MPPA_FMT_DCC, own, 1, 1, 0, 0, 1);
    $display("test lockout done");
    settle(2);
    `CHK("aux_output_seven", 1'b1, auxSeven)
    ahb(1, ADDR_CTRL, 32'h1);
    settle(1);
    `CHK("aux_output_nine", 1'b1, auxNine)
    `CHK("aux7off", 1'b0, auxSeven)
    @(posedge clock);
    analogPin <= 1'b1;
    settle(5);
    `CHK("aux9analog", 1'b0, auxNine)
    pkt(MPPA_FMT_AUTOREG, own, 1, 1, 0, 0, 1);
    `CHK("lockAgain", 1'b1, autoregLock)
    @(posedge clock);
    rst_n <= 1'b0;
    analogPin <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    own = RST_ADDRESS;
    settle(1);
    `CHK("parBack", 1'b1, parallelRxEnable)
    `CHK("lockReset", 1'b0, autoregLock)
    `CHK("stepsReset", MPPA_STEPS_14, speedSteps)
    ahb(0, ADDR_STATUS, 0);
    `CHK("status", 32'h10, rd)
    ahb(1, ADDR_CV29, 32'h2);
    ahb(1, ADDR_CV49, 32'h10);
    settle(2);
    `CHK("steps128", MPPA_STEPS_128, speedSteps)
    pkt(MPPA_FMT_DCC, own, 1, 1, 0, 0, 1);
    settle(1);
    `CHK("steps128Kept", MPPA_STEPS_128, speedSteps)
    $display("test buffer and power cycle done");
    report_and_stop();
  end
endmodule
`default_nettype wire
